// ---- include/apc_pkg.sv ----
package apc_pkg;
    localparam int APC_WIDTH = 10;
    localparam int APC_MSB = 9;
    localparam int APC_LATENCY = 7;
    localparam int APC_WARMUP = 20;
    localparam logic [4:0] APC_WARM_RESET = 5'h00;
    localparam logic [9:0] APC_WORD_RESET = 10'h000;
    typedef logic [9:0] apc_word_t;

    typedef enum logic [0:0]
    {
        APC_WARMING = 1'b0,
        APC_RUNNING = 1'b1
    } apc_state_e;

    function automatic apc_word_t apc_code(input apc_word_t ob, input logic twos);
        apc_code = {ob[APC_MSB] ^ twos, ob[APC_MSB-1:0]};
    endfunction
endpackage

// ---- src/apc_pipeline_output.sv ----
`timescale 1ns/100ps
module apc_pipeline_output
    import apc_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [9:0] analog_code,
    input wire logic output_format_select,
    input wire logic output_enable_n,
    output logic [9:0] sample_out,
    output logic [9:0] sample_oe_n,
    output logic sample_valid
);
    // Sample stage on falling edge; six pipe_q stages plus the sample_out register give seven rising stages, seven cycles total
    apc_word_t sample_q;
    apc_word_t pipe_q [0:APC_LATENCY-2];
    logic [4:0] warm_q;
    apc_state_e state_q;
    logic [4:0] run_cnt_q;

    always_ff @(negedge mclk)
    begin
        if (!resetn)
            sample_q <= APC_WORD_RESET;
        else
            sample_q <= analog_code;
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < APC_LATENCY - 1; i++)
                pipe_q[i] <= APC_WORD_RESET;
        end
        else
        begin
            pipe_q[0] <= sample_q;
            for (int i = 1; i < APC_LATENCY - 1; i++)
                pipe_q[i] <= pipe_q[i-1];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            sample_out <= APC_WORD_RESET;
        else
            sample_out <= apc_code(pipe_q[APC_LATENCY-2], output_format_select);
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            sample_oe_n <= {APC_WIDTH{1'b1}};
        else
            sample_oe_n <= {APC_WIDTH{output_enable_n}};
    end

    // Warm-up counter: output flagged invalid until dynamic stages settle
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            warm_q <= APC_WARM_RESET;
            state_q <= APC_WARMING;
            sample_valid <= 1'b0;
        end
        else
        begin
            case (state_q)
                APC_WARMING:
                begin
                    warm_q <= warm_q + 5'h01;
                    if (warm_q == 5'(APC_WARMUP - 1))
                    begin
                        state_q <= APC_RUNNING;
                        sample_valid <= 1'b1;
                    end
                end
                APC_RUNNING:
                    sample_valid <= 1'b1;
                default:
                    state_q <= APC_WARMING;
            endcase
        end
    end

    property p_twos;
        @(posedge mclk) disable iff (!resetn)
        resetn && output_format_select |=> sample_out[APC_MSB] != $past(pipe_q[APC_LATENCY-2][APC_MSB]);
    endproperty
    a_twos: assert property (p_twos) else $error("msb not inverted");

    property p_offset;
        @(posedge mclk) disable iff (!resetn)
        resetn && !output_format_select |=> sample_out == $past(pipe_q[APC_LATENCY-2]);
    endproperty
    a_offset: assert property (p_offset) else $error("offset binary mismatch");

    property p_latency;
        @(posedge mclk) disable iff (!resetn)
        ##7 !$past(output_format_select) |-> sample_out == $past(sample_q, 7);
    endproperty
    a_latency: assert property (p_latency) else $error("latency wrong");

    property p_oe;
        @(posedge mclk) disable iff (!resetn)
        output_enable_n |=> sample_oe_n == 10'h3ff;
    endproperty
    a_oe: assert property (p_oe) else $error("outputs not released");

    property p_warm;
        @(posedge mclk) disable iff (!resetn)
        $rose(resetn) |-> !sample_valid [*8];
    endproperty
    a_warm: assert property (p_warm) else $error("valid too early");

    property p_stream;
        @(posedge mclk) disable iff (!resetn)
        sample_valid |=> sample_valid;
    endproperty
    a_stream: assert property (p_stream) else $error("stream dropped");

    // Reference count of cycles since reset release, held once warm-up is over
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            run_cnt_q <= APC_WARM_RESET;
        else if (run_cnt_q != 5'(APC_WARMUP))
            run_cnt_q <= run_cnt_q + 5'h01;
    end

    property p_low_bits;
        @(posedge mclk) disable iff (!resetn)
        resetn |=> sample_out[APC_MSB-1:0] == $past(pipe_q[APC_LATENCY-2][APC_MSB-1:0]);
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("low bits altered");

    property p_latency_twos;
        @(posedge mclk) disable iff (!resetn)
        ##7 $past(output_format_select) |-> sample_out[APC_MSB] != $past(sample_q[APC_MSB], 7);
    endproperty
    a_latency_twos: assert property (p_latency_twos) else $error("latency wrong");

    // Falling-edge capture of the converter result
    property p_sample;
        @(negedge mclk) disable iff (!resetn)
        resetn |=> sample_q == $past(analog_code);
    endproperty
    a_sample: assert property (p_sample) else $error("sample not taken");

    property p_stage_first;
        @(posedge mclk) disable iff (!resetn)
        resetn |=> pipe_q[0] == $past(sample_q);
    endproperty
    a_stage_first: assert property (p_stage_first) else $error("first stage wrong");

    property p_stage_mid;
        @(posedge mclk) disable iff (!resetn)
        resetn |=> pipe_q[1] == $past(pipe_q[0]) && pipe_q[2] == $past(pipe_q[1])
            && pipe_q[3] == $past(pipe_q[2]) && pipe_q[4] == $past(pipe_q[3]);
    endproperty
    a_stage_mid: assert property (p_stage_mid) else $error("middle stage wrong");

    property p_stage_last;
        @(posedge mclk) disable iff (!resetn)
        resetn |=> pipe_q[APC_LATENCY-2] == $past(pipe_q[APC_LATENCY-3]);
    endproperty
    a_stage_last: assert property (p_stage_last) else $error("last stage wrong");

    property p_oe_drive;
        @(posedge mclk) disable iff (!resetn)
        resetn && !output_enable_n |=> sample_oe_n == 10'h000;
    endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("outputs not driven");

    property p_oe_uniform;
        @(posedge mclk) disable iff (!resetn)
        sample_oe_n == 10'h000 || sample_oe_n == 10'h3ff;
    endproperty
    a_oe_uniform: assert property (p_oe_uniform) else $error("enables split");

    // Reset returns every output to its idle value
    property p_reset_values;
        @(posedge mclk)
        !resetn |=> sample_out == APC_WORD_RESET && sample_oe_n == 10'h3ff && !sample_valid;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset outputs wrong");

    property p_reset_state;
        @(posedge mclk)
        !resetn |=> state_q == APC_WARMING && warm_q == APC_WARM_RESET
            && pipe_q[0] == APC_WORD_RESET;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_warm_early;
        @(posedge mclk) disable iff (!resetn)
        run_cnt_q != 5'(APC_WARMUP) |-> !sample_valid;
    endproperty
    a_warm_early: assert property (p_warm_early) else $error("valid before warm-up");

    property p_warm_late;
        @(posedge mclk) disable iff (!resetn)
        run_cnt_q == 5'(APC_WARMUP) |-> sample_valid;
    endproperty
    a_warm_late: assert property (p_warm_late) else $error("valid late");

    property p_warm_state;
        @(posedge mclk) disable iff (!resetn)
        state_q == APC_WARMING |-> !sample_valid;
    endproperty
    a_warm_state: assert property (p_warm_state) else $error("valid while warming");

    property p_run_valid;
        @(posedge mclk) disable iff (!resetn)
        state_q == APC_RUNNING |-> sample_valid;
    endproperty
    a_run_valid: assert property (p_run_valid) else $error("valid low while running");

    property p_warm_step;
        @(posedge mclk) disable iff (!resetn)
        resetn && state_q == APC_WARMING |=> warm_q == $past(warm_q) + 5'h01;
    endproperty
    a_warm_step: assert property (p_warm_step) else $error("warm-up count stalled");
endmodule // apc_pipeline_output

// ---- tb/apc_capture.sv ----
`timescale 1ns/100ps
module apc_capture
    import apc_pkg::*;
(
    input wire logic mclk,
    input wire logic [9:0] sample_out,
    input wire logic sample_valid,
    output apc_word_t captured
);
    always_ff @(posedge mclk)
    begin
        if (sample_valid)
            captured <= sample_out;
    end
endmodule // apc_capture

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import apc_pkg::*;
    logic mclk = 0, resetn = 0, fmt = 0, oe_n = 0, valid;
    logic [9:0] code_in = 10'h000;
    apc_word_t s_out, oe_bits, cap;
    int err_count = 0, tests_run = 0;
    always #12.5 mclk = ~mclk;
    apc_pipeline_output uut (.mclk(mclk), .resetn(resetn), .analog_code(code_in),
        .output_format_select(fmt), .output_enable_n(oe_n), .sample_out(s_out),
        .sample_oe_n(oe_bits), .sample_valid(valid));
    apc_capture cap_u (.mclk(mclk), .sample_out(s_out), .sample_valid(valid), .captured(cap));
    task chk(input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Full-scale and midscale codes fed back to back
    task coding(input logic f);
        logic [9:0] v [4] = '{10'h3ff, 10'h200, 10'h1ff, 10'h000};
        logic [9:0] tc [4] = '{10'h1ff, 10'h000, 10'h3ff, 10'h200};
        foreach (v[i])
        begin
            @(posedge mclk);
            fmt <= f;
            code_in <= v[i];
        end
        repeat (4) @(posedge mclk);
        foreach (v[i])
        begin
            #1 chk(s_out, f ? tc[i] : v[i]);
            @(posedge mclk);
        end
        #1 chk(cap, f ? tc[3] : v[3]);
    endtask
    task enable;
        @(posedge mclk);
        oe_n <= 1'b1;
        @(posedge mclk);
        #1 chk(oe_bits, 10'h3ff);
        @(posedge mclk);
        oe_n <= 1'b0;
        @(posedge mclk);
        #1 chk(oe_bits, 10'h000);
    endtask
    // Release reset and watch the warm-up flag rise after twenty cycles
    task warm_up;
        resetn <= 1'b1;
        repeat (19) @(posedge mclk);
        #1 chk({9'h000, valid}, 10'h000);
        @(posedge mclk);
        #1 chk({9'h000, valid}, 10'h001);
    endtask
    // Mid-run reset: outputs return to idle and warm-up starts over
    task restart;
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(s_out, APC_WORD_RESET);
        chk(oe_bits, 10'h3ff);
        chk({9'h000, valid}, 10'h000);
        @(posedge mclk);
        warm_up;
    endtask
    initial
    begin
        repeat (12) @(posedge mclk);
        warm_up;
        coding(1'b0);
        coding(1'b1);
        enable;
        restart;
        coding(1'b0);
        close_out;
    end
    initial
    begin
        #5000;
        err_count++;
        close_out;
    end
endmodule // testbench
